// ===== src/err_router_defs.svh
// Register map, field positions, reset values and masks of the error message router.
// Notes on behaviour
// - SERR enable bit 8: processor access above 4 GB and memory top sends SERR.
// - SERR enable bit 6: target-abort completion of our own link cycle sends SERR.
// - SERR enable bit 5: unimplemented special cycle sends SERR; clear bit sends nothing.
// - SERR enable bit 4: AGP access outside the graphics aperture sends SERR.
// - SERR enable bit 3: outside-aperture AGP access to 640 KB-1 MB or above top sends SERR.
// - SERR enable bit 2: invalid translation entry on aperture access sends SERR.
// - SERR enable bit 1: multiple-bit ECC error sends SERR.
// - SERR enable bit 0: single-bit ECC error sends SERR.
// - SMI enable bit 1: multiple-bit ECC error sends SMI.
// - SMI enable bit 0: single-bit ECC error sends SMI.
// - One message per condition at most; software enables only one message kind.
// - Every SERR message also needs the global SERR enable of the command register.
// - SMI enable register is 16 bits, resets to zero, only bits 1:0 writable.
// - A message goes out only when enabled and its status flag becomes set.
// - SERR is signalled only as a hub-link message, never on a pin.
`ifndef ERR_ROUTER_DEFS_SVH
`define ERR_ROUTER_DEFS_SVH

`define ERT_ADDR_SERR_EN    8'hca
`define ERT_ADDR_SMI_EN     8'hcc
`define ERT_ADDR_STATUS     8'hd0
`define ERT_ADDR_IRQ_MASK   8'hd2
`define ERT_ADDR_PCI_COMMAND_REGISTER     8'hd4

`define ERT_SERR_EN_RESET   16'h0000
`define ERT_SMI_EN_RESET    16'h0000
`define ERT_IRQ_MASK_RESET  16'h0000
`define ERT_PCI_COMMAND_REGISTER_RESET    16'h0000

`define ERT_SERR_EN_WMASK   16'h017f
`define ERT_SMI_EN_WMASK    16'h0003
`define ERT_PCI_COMMAND_REGISTER_WMASK    16'h0100
`define ERT_COND_MASK       9'h17f

`define ERT_PCI_COMMAND_REGISTER_SERR_BIT 8
`define ERT_NUM_COND        9
`define ERT_NUM_ECC         2

`endif

// ===== src/err_router_pkg.sv
// Types shared by the error message router.
package err_router_pkg;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_SEND = 2'b10
  } msg_state_t;

  typedef enum logic {
    KIND_SERR = 1'b0,
    KIND_SMI  = 1'b1
  } msg_kind_t;

endpackage

// ===== src/error_message_enable_router.sv
// Error status flags, enable registers and hub-link message issue for error events.
`timescale 1ns/10ps
`include "err_router_defs.svh"
module error_message_enable_router (
  input  wire logic                  CLK_SYS,
  input  wire logic                  RESET_N,
  input  wire logic [7:0]            REG_ADDR,
  input  wire logic [15:0]           REG_WDATA,
  input  wire logic                  REG_WR,
  input  wire logic                  REG_RD,
  output logic [15:0]                REG_RDATA,
  input  wire logic [8:0]            ERR_EVENT,
  output logic                       MSG_REQ,
  output err_router_pkg::msg_kind_t  MSG_KIND,
  output logic [3:0]                 MSG_CODE,
  input  wire logic                  MSG_ACK,
  output logic                       IRQ
);
  import err_router_pkg::*;

  logic [15:0] serr_error_enable;
  logic [15:0] smi_error_enable;
  logic [15:0] irq_mask;
  logic [15:0] pci_command_register;
  logic [8:0]  error_status;
  logic [8:0]  pend_serr;
  logic [1:0]  pend_smi;
  msg_state_t  state;

  // Register decode.
  wire sel_serr   = (REG_ADDR == `ERT_ADDR_SERR_EN);
  wire sel_smi    = (REG_ADDR == `ERT_ADDR_SMI_EN);
  wire sel_status = (REG_ADDR == `ERT_ADDR_STATUS);
  wire sel_mask   = (REG_ADDR == `ERT_ADDR_IRQ_MASK);
  wire sel_pci_command_register = (REG_ADDR == `ERT_ADDR_PCI_COMMAND_REGISTER);
  wire wr_serr    = REG_WR & sel_serr;
  wire wr_smi     = REG_WR & sel_smi;
  wire wr_status  = REG_WR & sel_status;
  wire wr_mask    = REG_WR & sel_mask;
  wire wr_pci_command_register  = REG_WR & sel_pci_command_register;

  wire [15:0] status_word = {7'h00, error_status};
  wire [15:0] read_mux    = sel_serr   ? serr_error_enable    :
                            sel_smi    ? smi_error_enable     :
                            sel_status ? status_word          :
                            sel_mask   ? irq_mask             :
                            sel_pci_command_register ? pci_command_register : 16'h0000;

  always_ff @(posedge CLK_SYS or negedge RESET_N) begin
    if (!RESET_N) begin
      serr_error_enable <= `ERT_SERR_EN_RESET;
      smi_error_enable  <= `ERT_SMI_EN_RESET;
    end else begin
      if (wr_serr) serr_error_enable <= REG_WDATA & `ERT_SERR_EN_WMASK;
      if (wr_smi)  smi_error_enable  <= REG_WDATA & `ERT_SMI_EN_WMASK;
    end
  end

  always_ff @(posedge CLK_SYS or negedge RESET_N) begin
    if (!RESET_N) begin
      irq_mask             <= `ERT_IRQ_MASK_RESET;
      pci_command_register <= `ERT_PCI_COMMAND_REGISTER_RESET;
    end else begin
      if (wr_mask)   irq_mask             <= REG_WDATA & {7'h00, `ERT_COND_MASK};
      if (wr_pci_command_register) pci_command_register <= REG_WDATA & `ERT_PCI_COMMAND_REGISTER_WMASK;
    end
  end

  // Read data stand only in the cycle after the strobe; the slave never stalls.
  always_ff @(posedge CLK_SYS or negedge RESET_N) begin
    if (!RESET_N) begin
      REG_RDATA <= 16'h0000;
    end else begin
      REG_RDATA <= REG_RD ? read_mux : 16'h0000;
    end
  end

  // Error status flags, one per condition; bit 7 has no condition and stays zero.
  wire [8:0] flag_set = ERR_EVENT & `ERT_COND_MASK;
  wire [8:0] flag_clr = {9{wr_status}} & REG_WDATA[8:0];

  genvar k;
  generate
    for (k = 0; k < `ERT_NUM_COND; k++) begin : g_flag
      sticky_flag u_flag (
        .CLK_SYS (CLK_SYS),
        .RESET_N (RESET_N),
        .set     (flag_set[k]),
        .clr     (flag_clr[k]),
        .flag    (error_status[k])
      );
    end
  endgenerate

  wire [8:0] flag_rise = flag_set & ~error_status;

  wire       serr_global = pci_command_register[`ERT_PCI_COMMAND_REGISTER_SERR_BIT];
  wire [8:0] serr_qual   = serr_error_enable[8:0] & {9{serr_global}};
  wire [1:0] smi_qual    = smi_error_enable[1:0] & ~serr_qual[1:0];
  wire [8:0] set_serr    = flag_rise & serr_qual;
  wire [1:0] set_smi     = flag_rise[1:0] & smi_qual;

  // Lowest pending SERR condition first, then SMI; a fixed order keeps it simple
  // at the cost of fairness, which matters little for rare error traffic.
  logic       pick_found;
  msg_kind_t  pick_kind;
  logic [3:0] pick_code;
  always_comb begin
    pick_found = 1'b0;
    pick_kind  = KIND_SERR;
    pick_code  = 4'h0;
    for (int i = `ERT_NUM_ECC - 1; i >= 0; i--) begin
      if (pend_smi[i]) begin
        pick_found = 1'b1;
        pick_kind  = KIND_SMI;
        pick_code  = 4'(i);
      end
    end
    for (int i = `ERT_NUM_COND - 1; i >= 0; i--) begin
      if (pend_serr[i]) begin
        pick_found = 1'b1;
        pick_kind  = KIND_SERR;
        pick_code  = 4'(i);
      end
    end
  end

  wire       take      = (state == ST_IDLE) & pick_found;
  wire [8:0] pick_hot  = 9'h001 << pick_code;
  wire [8:0] clr_serr  = (take & (pick_kind == KIND_SERR)) ? pick_hot : 9'h000;
  wire [1:0] clr_smi   = (take & (pick_kind == KIND_SMI)) ? pick_hot[1:0] : 2'h0;
  wire       done      = (state == ST_SEND) & MSG_ACK;

  always_ff @(posedge CLK_SYS or negedge RESET_N) begin
    if (!RESET_N) begin
      pend_serr <= 9'h000;
      pend_smi  <= 2'h0;
    end else begin
      pend_serr <= (pend_serr & ~clr_serr) | set_serr;
      pend_smi  <= (pend_smi & ~clr_smi) | set_smi;
    end
  end

  always_ff @(posedge CLK_SYS or negedge RESET_N) begin
    if (!RESET_N) begin
      state <= ST_IDLE;
    end else begin
      case (state)
        ST_IDLE: state <= pick_found ? ST_SEND : ST_IDLE;
        ST_SEND: state <= MSG_ACK ? ST_IDLE : ST_SEND;
        default: state <= ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge CLK_SYS or negedge RESET_N) begin
    if (!RESET_N) begin
      MSG_REQ  <= 1'b0;
      MSG_KIND <= KIND_SERR;
      MSG_CODE <= 4'h0;
    end else begin
      if (take) begin
        MSG_REQ  <= 1'b1;
        MSG_KIND <= pick_kind;
        MSG_CODE <= pick_code;
      end else if (done) begin
        MSG_REQ  <= 1'b0;
      end
    end
  end

  // Interrupt is a plain level; it falls as soon as software clears the flag.
  assign IRQ = |(status_word & irq_mask);

  // Checks.
  property p_serr_capture;
    @(posedge CLK_SYS) disable iff (!RESET_N)
      (|set_serr) |=> ((pend_serr & $past(set_serr)) == $past(set_serr));
  endproperty
  a_serr_capture: assert property (p_serr_capture)
    else $error("Enabled SERR condition did not queue a message.");

  property p_serr_blocked;
    @(posedge CLK_SYS) disable iff (!RESET_N)
      (|(flag_rise & ~serr_qual & ~pend_serr & ~clr_serr)) |=>
        ((pend_serr & $past(flag_rise & ~serr_qual & ~pend_serr)) == 9'h000);
  endproperty
  a_serr_blocked: assert property (p_serr_blocked)
    else $error("SERR message queued for a disabled condition.");

  property p_smi_capture;
    @(posedge CLK_SYS) disable iff (!RESET_N)
      (|set_smi) |=> ((pend_smi & $past(set_smi)) == $past(set_smi));
  endproperty
  a_smi_capture: assert property (p_smi_capture)
    else $error("Enabled SMI condition did not queue a message.");

  property p_one_kind;
    @(posedge CLK_SYS) disable iff (!RESET_N)
      (pend_smi & pend_serr[1:0]) == 2'h0;
  endproperty
  a_one_kind: assert property (p_one_kind)
    else $error("Both SERR and SMI queued for one ECC condition.");

  property p_req_hold;
    @(posedge CLK_SYS) disable iff (!RESET_N)
      (MSG_REQ && !MSG_ACK) |=> (MSG_REQ && $stable(MSG_CODE) && $stable(MSG_KIND));
  endproperty
  a_req_hold: assert property (p_req_hold)
    else $error("Message request dropped or changed before acknowledge.");

  property p_req_drop;
    @(posedge CLK_SYS) disable iff (!RESET_N)
      (MSG_REQ && MSG_ACK) |=> !MSG_REQ;
  endproperty
  a_req_drop: assert property (p_req_drop)
    else $error("Message request not withdrawn after acknowledge.");

  property p_no_repeat;
    @(posedge CLK_SYS) disable iff (!RESET_N)
      (error_status[0] && $past(error_status[0])) |-> !set_serr[0] && !set_smi[0];
  endproperty
  a_no_repeat: assert property (p_no_repeat)
    else $error("Message raised for a flag that was already set.");

  property p_smi_reserved;
    @(posedge CLK_SYS) disable iff (!RESET_N)
      wr_smi |=> (smi_error_enable == ($past(REG_WDATA) & `ERT_SMI_EN_WMASK));
  endproperty
  a_smi_reserved: assert property (p_smi_reserved)
    else $error("Reserved SMI enable bits became set.");

  property p_issue_latency;
    @(posedge CLK_SYS) disable iff (!RESET_N)
      ((state == ST_IDLE) && pick_found) |=> MSG_REQ ##0 (state == ST_SEND);
  endproperty
  a_issue_latency: assert property (p_issue_latency)
    else $error("Pending message not issued one cycle after idle.");

  property p_serr_reserved;
    @(posedge CLK_SYS) disable iff (!RESET_N)
      wr_serr |=> (serr_error_enable == ($past(REG_WDATA) & `ERT_SERR_EN_WMASK));
  endproperty
  a_serr_reserved: assert property (p_serr_reserved)
    else $error("SERR enable register holds a value other than the masked write.");

  property p_smi_read_zero;
    @(posedge CLK_SYS) disable iff (!RESET_N)
      (REG_RD && sel_smi) |=> (REG_RDATA[15:2] == 14'h0000);
  endproperty
  a_smi_read_zero: assert property (p_smi_read_zero)
    else $error("Reserved SMI enable bits read back as nonzero.");

  property p_global_gate;
    @(posedge CLK_SYS) disable iff (!RESET_N)
      !pci_command_register[`ERT_PCI_COMMAND_REGISTER_SERR_BIT] |=>
        ((pend_serr & ~$past(pend_serr)) == 9'h000);
  endproperty
  a_global_gate: assert property (p_global_gate)
    else $error("SERR message queued while the global SERR enable was clear.");

  property p_smi_off;
    @(posedge CLK_SYS) disable iff (!RESET_N)
      (smi_error_enable[1:0] == 2'b00) |=> ((pend_smi & ~$past(pend_smi)) == 2'h0);
  endproperty
  a_smi_off: assert property (p_smi_off)
    else $error("SMI message queued with both SMI enables clear.");

  property p_serr_enable_needed;
    @(posedge CLK_SYS) disable iff (!RESET_N)
      ((pend_serr & ~$past(pend_serr)) & ~$past(serr_error_enable[8:0])) == 9'h000;
  endproperty
  a_serr_enable_needed: assert property (p_serr_enable_needed)
    else $error("SERR message queued for a condition whose enable was clear.");

  property p_smi_code;
    @(posedge CLK_SYS) disable iff (!RESET_N)
      (MSG_REQ && (MSG_KIND == KIND_SMI)) |-> (MSG_CODE <= 4'h1);
  endproperty
  a_smi_code: assert property (p_smi_code)
    else $error("SMI message carries a condition other than an ECC error.");

  property p_code_valid;
    @(posedge CLK_SYS) disable iff (!RESET_N)
      MSG_REQ |-> ((MSG_CODE <= 4'h8) && (MSG_CODE != 4'h7));
  endproperty
  a_code_valid: assert property (p_code_valid)
    else $error("Message carries an unknown condition code.");

  property p_req_in_send;
    @(posedge CLK_SYS) disable iff (!RESET_N)
      MSG_REQ |-> (state == ST_SEND);
  endproperty
  a_req_in_send: assert property (p_req_in_send)
    else $error("Message request shown outside the send state.");

endmodule

// ===== src/sticky_flag.sv
// One sticky status flag: hardware sets it, software clears it by writing a one.
`timescale 1ns/10ps
module sticky_flag (
  input  wire logic CLK_SYS,
  input  wire logic RESET_N,
  input  wire logic set,
  input  wire logic clr,
  output logic      flag
);

  // A set arriving with a clear keeps the flag, so no event is lost.
  always_ff @(posedge CLK_SYS or negedge RESET_N) begin
    if (!RESET_N) begin
      flag <= 1'b0;
    end else begin
      flag <= set | (flag & ~clr);
    end
  end

endmodule

// ===== verification/error_message_enable_router_tb_top.sv
// Self-checking bench for the error message router with a hub link partner.
`timescale 1ns/10ps
module error_message_enable_router_tb_top;
  import err_router_pkg::*;
  logic        clk_sys = 1'b0;
  logic        reset_n = 1'b0;
  logic        reg_wr = 1'b0;
  logic        reg_rd = 1'b0;
  logic        rd_d = 1'b0;
  logic [7:0]  reg_addr = 8'h00;
  logic [15:0] reg_wdata = 16'h0000;
  logic [8:0]  err_event = 9'h000;
  logic [2:0]  ack_delay = 3'h0;
  logic [15:0] reg_rdata;
  logic        msg_req;
  logic        msg_ack;
  logic        irq;
  msg_kind_t   msg_kind;
  logic [3:0]  msg_code;
  logic [15:0] rq[$];
  logic [4:0]  mq[$];
  logic [15:0] v;
  logic [15:0] e16;
  logic [4:0]  e5;
  int          err_total = 0;
  int          checked = 0;
  int          seed = 32'hf67250c8;
  int          k;

  always #5 clk_sys = ~clk_sys;

  error_message_enable_router dut (
    .CLK_SYS(clk_sys), .RESET_N(reset_n), .REG_ADDR(reg_addr), .REG_WDATA(reg_wdata),
    .REG_WR(reg_wr), .REG_RD(reg_rd), .REG_RDATA(reg_rdata), .ERR_EVENT(err_event),
    .MSG_REQ(msg_req), .MSG_KIND(msg_kind), .MSG_CODE(msg_code), .MSG_ACK(msg_ack), .IRQ(irq)
  );

  hub_link_partner link (
    .CLK_SYS(clk_sys), .RESET_N(reset_n), .MSG_REQ(msg_req), .ACK_DELAY(ack_delay),
    .MSG_ACK(msg_ack)
  );

  task fail(input string m);
    err_total++;
    $display("Error %0t: %s", $time, m);
  endtask

  task results;
    $display("Comparisons %0d, mismatches %0d", checked, err_total);
    if (err_total == 0 && checked > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  // Strobes drop for one cycle between accesses so no signal is assigned twice at one edge.
  task wr(input logic [7:0] a, input logic [15:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
    @(posedge clk_sys);
  endtask

  task rd(input logic [7:0] a, input logic [15:0] e);
    rq.push_back(e);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    @(posedge clk_sys);
  endtask

  task ev(input logic [8:0] m);
    err_event <= m;
    @(posedge clk_sys);
    err_event <= 9'h000;
    @(posedge clk_sys);
  endtask

  task chk(input logic got, input logic exp);
    checked++;
    if (got !== exp) fail("interrupt level mismatch");
  endtask

  task drain(input string name);
    repeat (40) @(posedge clk_sys);
    checked++;
    if (mq.size() != 0) fail("expected message never sent");
    mq.delete();
    wr(8'hd0, 16'h017f);
    $display("Test %s finished", name);
  endtask

  // Results are compared in order as the design produces them.
  always @(posedge clk_sys) begin
    if (rd_d) begin
      checked++;
      e16 = rq.pop_front();
      if (reg_rdata !== e16) fail("read data mismatch");
    end
    rd_d <= reg_rd;
    if (msg_req === 1'b1 && msg_ack === 1'b1) begin
      checked++;
      if (mq.size() == 0) fail("unexpected message");
      else begin
        e5 = mq.pop_front();
        if ({msg_kind, msg_code} !== e5) fail("message kind or code mismatch");
      end
    end
  end

  initial begin
    repeat (8) @(posedge clk_sys);
    reset_n <= 1'b1;
    @(posedge clk_sys);
    rd(8'hca, 16'h0000);
    rd(8'hcc, 16'h0000);
    rd(8'hd4, 16'h0000);
    v = $random(seed);
    wr(8'hca, v);
    rd(8'hca, v & 16'h017f);
    wr(8'hcc, 16'hffff);
    rd(8'hcc, 16'h0003);
    wr(8'hd4, 16'hffff);
    rd(8'hd4, 16'h0100);
    rd(8'he0, 16'h0000);
    drain("registers");
    wr(8'hca, 16'h017f);
    wr(8'hd4, 16'h0000);
    ev(9'h010);
    rd(8'hd0, 16'h0010);
    drain("global gate");
    wr(8'hd4, 16'h0100);
    for (k = 0; k < 9; k++) begin
      if (k != 7) begin
        ack_delay <= 3'($random(seed));
        mq.push_back({KIND_SERR, 4'(k)});
        ev(9'(1 << k));
        repeat (12) @(posedge clk_sys);
      end
    end
    ev(9'h001);
    drain("serr per condition");
    wr(8'hca, 16'h0000);
    wr(8'hcc, 16'h0003);
    ack_delay <= 3'h7;
    ev(9'h020);
    mq.push_back({KIND_SMI, 4'h0});
    mq.push_back({KIND_SMI, 4'h1});
    ev(9'h003);
    drain("smi");
    wr(8'hca, 16'h0003);
    mq.push_back({KIND_SERR, 4'h1});
    ev(9'h002);
    drain("one message per condition");
    wr(8'hca, 16'h0000);
    wr(8'hcc, 16'h0000);
    ev(9'h003);
    rd(8'hd0, 16'h0003);
    drain("ecc enables clear");
    wr(8'hd2, 16'h017f);
    ev(9'h100);
    chk(irq, 1'b1);
    wr(8'hd2, 16'h0000);
    chk(irq, 1'b0);
    wr(8'hd2, 16'h017f);
    chk(irq, 1'b1);
    wr(8'hd0, 16'h0100);
    chk(irq, 1'b0);
    $display("Test interrupt finished");
    results;
  end

  initial begin
    #100000;
    err_total++;
    $display("Error %0t: watchdog expired", $time);
    results;
  end
endmodule

// ===== verification/hub_link_partner.sv
// Far end of the hub link: accepts each message after a chosen number of cycles.
`timescale 1ns/10ps
module hub_link_partner (
  input  wire logic       CLK_SYS,
  input  wire logic       RESET_N,
  input  wire logic       MSG_REQ,
  input  wire logic [2:0] ACK_DELAY,
  output logic            MSG_ACK
);
  logic [2:0] wait_cnt;

  always_ff @(posedge CLK_SYS or negedge RESET_N) begin
    if (!RESET_N) begin
      MSG_ACK  <= 1'b0;
      wait_cnt <= 3'h0;
    end else if (MSG_ACK) begin
      MSG_ACK  <= 1'b0;
    end else if (MSG_REQ && wait_cnt == ACK_DELAY) begin
      MSG_ACK  <= 1'b1;
      wait_cnt <= 3'h0;
    end else if (MSG_REQ) begin
      wait_cnt <= wait_cnt + 3'h1;
    end
  end
endmodule
